// ===== ind_access_port.sv
// Indirect access port with SRAM test path, behind the register port.
// Assumes the serial decoder issues one-cycle read/write strobes and
// that the internal space answers a read one cycle after its strobe.
//
// Functional notes
// - Three-bit index picks one of eight SRAMs
// - Bit 13 picks luminance group, else chrominance
// - Bit 14 reads output buffer SRAM instead
// - Test write loads all seventeen SRAMs together
// - Test read loads selected word into data
// - Only data register access starts a transfer
// - Control bits 10:0 hold indirect address
// - Burst bit flags serial burst, max 16
// - Bit 14 chooses indirect write or read unless bit 15 is set
// - Bit 15 increments address after each access
// - Test address 0..799 auto-increments per write if test write set, per read if not
// - Offsets 0x20..0x2E alias the data register
// - Path select picks test SRAMs or indirect space
`timescale 1ns/100ps

module ind_access_port
  import ind_access_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // Register port from the serial decoder or microcontroller
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [REG_W-1:0]       i_reg_wdata,
  output logic      [REG_W-1:0]       o_reg_rdata,
  output logic                        o_reg_rvalid,
  output logic                        o_busy,
  output logic                        o_burst_mode,
  // Test path select level
  input  wire logic                   i_sram_test_path_select,
  // Indirect register and memory space
  output logic      [IND_ADDR_W-1:0]  o_ind_addr,
  output logic                        o_ind_wr,
  output logic                        o_ind_rd,
  output logic      [REG_W-1:0]       o_ind_wdata,
  input  wire logic [REG_W-1:0]       i_ind_rdata
);

  // All state of the block
  typedef struct packed {
    seq_state_t              st;          // Sequencer state
    logic [TST_ADDR_W-1:0]   tst_addr;    // Test SRAM address
    logic [TST_IDX_W-1:0]    tst_idx;     // Index in group
    logic                    tst_luma;    // Luminance group
    logic                    tst_obuf;    // Output buffer read
    logic                    tst_we;      // Test write enable
    logic [IND_ADDR_W-1:0]   ind_addr;    // Indirect address
    logic                    burst_en;    // Serial burst mode
    logic                    ind_wr_en;   // Indirect write enable
    logic                    auto_inc;    // Address auto-increment
    logic [REG_W-1:0]        data;        // Indirect data word
    logic [REG_W-1:0]        rdata;       // Read answer
    logic                    rvalid;      // Read answer strobe
    logic                    ind_wr;      // Indirect write strobe
    logic                    ind_rd;      // Indirect read strobe
    logic [IND_ADDR_W-1:0]   ind_aout;    // Address on the bus
    logic                    sram_wr;     // Broadcast SRAM write
    logic [TST_ADDR_W-1:0]   sram_waddr;  // SRAM write address
    logic                    busy;        // Fetch in progress
    logic                    fetch_rd;    // Fetch answers a read
    logic                    sram_wait;   // Bank read lags a write
  } state_t;

  state_t                      cur_ff;      // Registered state
  state_t                      nxt_cur;     // Next state
  logic [SRAM_COUNT*REG_W-1:0] sram_rdata;  // All SRAM read words
  logic [TST_ADDR_W-1:0]       sram_addr;   // Shared SRAM address
  logic [SRAM_IDX_W-1:0]       sel_idx;     // Selected SRAM number
  logic                        is_data;     // Data register hit
  logic                        acc;         // Any access strobe

  // Maps the selection fields to an SRAM number
  function automatic logic [SRAM_IDX_W-1:0] sram_index(
    input logic                 obuf,
    input logic                 luma,
    input logic [TST_IDX_W-1:0] idx
  );
    logic [SRAM_IDX_W-1:0] base;
    base = luma ? LUMA_BASE : CHROMA_BASE;
    if (obuf)
    begin
      sram_index = OBUF_INDEX;
    end
    else
    begin
      sram_index = base + SRAM_IDX_W'(idx);
    end
  endfunction : sram_index

  // Test address step with wrap after the last word
  function automatic logic [TST_ADDR_W-1:0] tst_step(
    input logic [TST_ADDR_W-1:0] a
  );
    tst_step = (a >= TST_ADDR_LAST) ? '0 : a + 10'h001;
  endfunction : tst_step

  // True for the data register and its burst aliases
  function automatic logic data_hit(input logic [7:0] a);
    data_hit = (a == OFS_IND_DATA) ||
               ((a >= OFS_ALIAS_FIRST) && (a <= OFS_ALIAS_LAST));
  endfunction : data_hit

  assign is_data = data_hit(i_reg_addr);
  assign acc     = i_reg_wr || i_reg_rd;
  assign sel_idx = sram_index(cur_ff.tst_obuf, cur_ff.tst_luma,
                              cur_ff.tst_idx);
  // Write uses its latched address, reads the live test address
  assign sram_addr = cur_ff.sram_wr ? cur_ff.sram_waddr : cur_ff.tst_addr;

  // Seventeen test SRAMs
  sram_test_bank u_bank (
    .i_clk   (i_clk),
    .i_wr    (cur_ff.sram_wr),
    .i_addr  (sram_addr),
    .i_wdata (cur_ff.data),
    .o_rdata (sram_rdata)
  );

  // Next-state logic
  always_comb
  begin
    nxt_cur         = cur_ff;
    // Strobes last one cycle
    nxt_cur.rvalid  = 1'b0;
    nxt_cur.ind_wr  = 1'b0;
    nxt_cur.ind_rd  = 1'b0;
    nxt_cur.sram_wr = 1'b0;

    case (cur_ff.st)
      ST_IDLE:
      begin
        // Accesses only taken while idle
        if (acc && (i_reg_addr == OFS_RAM_TEST_CTRL))
        begin
          if (i_reg_wr)
          begin
            nxt_cur.tst_addr = i_reg_wdata[TST_ADDR_LSB +: TST_ADDR_W];
            nxt_cur.tst_idx  = i_reg_wdata[TST_IDX_LSB +: TST_IDX_W];
            nxt_cur.tst_luma = i_reg_wdata[TST_LUMA_BIT];
            nxt_cur.tst_obuf = i_reg_wdata[TST_OBUF_BIT];
            nxt_cur.tst_we   = i_reg_wdata[TST_WE_BIT];
          end
          else
          begin
            nxt_cur.rdata  = '0;
            nxt_cur.rdata[TST_ADDR_LSB +: TST_ADDR_W] = cur_ff.tst_addr;
            nxt_cur.rdata[TST_IDX_LSB +: TST_IDX_W]   = cur_ff.tst_idx;
            nxt_cur.rdata[TST_LUMA_BIT] = cur_ff.tst_luma;
            nxt_cur.rdata[TST_OBUF_BIT] = cur_ff.tst_obuf;
            nxt_cur.rdata[TST_WE_BIT]   = cur_ff.tst_we;
            nxt_cur.rvalid = 1'b1;
          end
        end
        else if (acc && (i_reg_addr == OFS_IND_CTRL))
        begin
          if (i_reg_wr)
          begin
            nxt_cur.ind_addr  = i_reg_wdata[IND_ADDR_LSB +: IND_ADDR_W];
            nxt_cur.burst_en  = i_reg_wdata[IND_BURST_BIT];
            nxt_cur.ind_wr_en = i_reg_wdata[IND_WR_BIT];
            nxt_cur.auto_inc  = i_reg_wdata[IND_AINC_BIT];
          end
          else
          begin
            nxt_cur.rdata = '0;
            nxt_cur.rdata[IND_ADDR_LSB +: IND_ADDR_W] = cur_ff.ind_addr;
            nxt_cur.rdata[IND_BURST_BIT] = cur_ff.burst_en;
            nxt_cur.rdata[IND_WR_BIT]    = cur_ff.ind_wr_en;
            nxt_cur.rdata[IND_AINC_BIT]  = cur_ff.auto_inc;
            nxt_cur.rvalid = 1'b1;
          end
        end
        else if (acc && is_data)
        begin
          if (i_reg_wr)
          begin
            nxt_cur.data = i_reg_wdata;
          end
          if (i_sram_test_path_select)
          begin
            if (cur_ff.tst_we && i_reg_wr)
            begin
              nxt_cur.sram_wr    = 1'b1;
              nxt_cur.sram_waddr = cur_ff.tst_addr;
              nxt_cur.tst_addr   = tst_step(cur_ff.tst_addr);
            end
            else if (!cur_ff.tst_we && i_reg_rd)
            begin
              nxt_cur.st = ST_SRAM_RD;
              nxt_cur.sram_wait = cur_ff.sram_wr;  // Write lands this edge
            end
            else if (i_reg_rd)
            begin
              nxt_cur.rdata  = cur_ff.data;
              nxt_cur.rvalid = 1'b1;
            end
          end
          else
          begin
            // direction, access type rules under auto-increment
            if (i_reg_wr && (cur_ff.ind_wr_en || cur_ff.auto_inc))
            begin
              nxt_cur.ind_wr   = 1'b1;
              nxt_cur.ind_aout = cur_ff.ind_addr;
              if (cur_ff.auto_inc)
              begin
                nxt_cur.ind_addr = cur_ff.ind_addr + 11'h001;
              end
            end
            else if (i_reg_rd && (!cur_ff.ind_wr_en || cur_ff.auto_inc))
            begin
              nxt_cur.fetch_rd = 1'b1;
              nxt_cur.ind_rd   = 1'b1;
              nxt_cur.ind_aout = cur_ff.ind_addr;
              nxt_cur.st       = ST_IND_STRB;
            end
            else if (i_reg_wr)
            begin
              nxt_cur.fetch_rd = 1'b0;
              nxt_cur.ind_rd   = 1'b1;
              nxt_cur.ind_aout = cur_ff.ind_addr;
              nxt_cur.st       = ST_IND_STRB;
            end
            else
            begin
              nxt_cur.rdata  = cur_ff.data;
              nxt_cur.rvalid = 1'b1;
            end
          end
        end
        else if (i_reg_rd)
        begin
          // Unmapped read answers zero
          nxt_cur.rdata  = '0;
          nxt_cur.rvalid = 1'b1;
        end
      end

      ST_SRAM_RD:
      begin
        // Bank word is one edge stale after a broadcast write
        if (cur_ff.sram_wait)
        begin
          nxt_cur.sram_wait = 1'b0;
        end
        else
        begin
          nxt_cur.data     = sram_rdata[sel_idx*REG_W +: REG_W];
          nxt_cur.rdata    = sram_rdata[sel_idx*REG_W +: REG_W];
          nxt_cur.rvalid   = 1'b1;
          nxt_cur.tst_addr = tst_step(cur_ff.tst_addr);
          nxt_cur.st       = ST_IDLE;
        end
      end

      ST_IND_STRB:
      begin
        // Strobe seen, data follows next cycle
        nxt_cur.st = ST_IND_CAPT;
      end

      ST_IND_CAPT:
      begin
        nxt_cur.data = i_ind_rdata;
        // Answer only when the host asked for a read
        nxt_cur.rdata  = i_ind_rdata;
        nxt_cur.rvalid = cur_ff.fetch_rd;
        if (cur_ff.auto_inc)
        begin
          nxt_cur.ind_addr = cur_ff.ind_addr + 11'h001;
        end
        nxt_cur.st = ST_IDLE;
      end

      default:
      begin
        nxt_cur.st = ST_IDLE;
      end
    endcase
    // Busy flag registered from the next state
    nxt_cur.busy = (nxt_cur.st != ST_IDLE);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cur_ff            <= '0;
      cur_ff.st         <= ST_IDLE;
      cur_ff.tst_addr   <= RST_RAM_TEST_CTRL[TST_ADDR_LSB +: TST_ADDR_W];
      cur_ff.ind_addr   <= RST_IND_CTRL[IND_ADDR_LSB +: IND_ADDR_W];
      cur_ff.data       <= RST_IND_DATA;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from the state register
  assign o_reg_rdata  = cur_ff.rdata;
  assign o_reg_rvalid = cur_ff.rvalid;
  assign o_busy       = cur_ff.busy;
  assign o_burst_mode = cur_ff.burst_en;
  assign o_ind_addr   = cur_ff.ind_aout;
  assign o_ind_wr     = cur_ff.ind_wr;
  assign o_ind_rd     = cur_ff.ind_rd;
  assign o_ind_wdata  = cur_ff.data;

endmodule : ind_access_port

// ===== ind_access_pkg.sv
// Constants for the indirect access port and the SRAM test path.
// Assumes a single clock domain and a 16-bit register port.
package ind_access_pkg;

  // Register offsets on the register port
  localparam logic [7:0] OFS_RAM_TEST_CTRL   = 8'h1D;
  localparam logic [7:0] OFS_IND_CTRL        = 8'h1E;
  localparam logic [7:0] OFS_IND_DATA        = 8'h1F;
  localparam logic [7:0] OFS_ALIAS_FIRST     = 8'h20;
  localparam logic [7:0] OFS_ALIAS_LAST      = 8'h2E;

  // Widths
  localparam int REG_W      = 16;
  localparam int IND_ADDR_W = 11;
  localparam int TST_ADDR_W = 10;
  localparam int SRAM_IDX_W = 5;

  // SRAM test geometry
  localparam int SRAM_COUNT  = 17;
  localparam int SRAM_DEPTH  = 800;
  localparam logic [TST_ADDR_W-1:0] TST_ADDR_LAST = 10'h31F;

  // Fields of the RAM test control word
  localparam int TST_ADDR_LSB = 0;
  localparam int TST_IDX_LSB  = 10;
  localparam int TST_IDX_W    = 3;
  localparam int TST_LUMA_BIT = 13;
  localparam int TST_OBUF_BIT = 14;
  localparam int TST_WE_BIT   = 15;

  // Fields of the indirect access control word
  localparam int IND_ADDR_LSB  = 0;
  localparam int IND_BURST_BIT = 13;
  localparam int IND_WR_BIT    = 14;
  localparam int IND_AINC_BIT  = 15;

  // SRAM numbering: luminance group, chrominance group, output buffer
  localparam logic [SRAM_IDX_W-1:0] LUMA_BASE   = 5'h00;
  localparam logic [SRAM_IDX_W-1:0] CHROMA_BASE = 5'h08;
  localparam logic [SRAM_IDX_W-1:0] OBUF_INDEX  = 5'h10;

  // Reset values
  localparam logic [REG_W-1:0] RST_RAM_TEST_CTRL = 16'h0000;
  localparam logic [REG_W-1:0] RST_IND_CTRL      = 16'h0000;
  localparam logic [REG_W-1:0] RST_IND_DATA      = 16'h0000;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_SRAM_RD  = 2'b01,
    ST_IND_STRB = 2'b10,
    ST_IND_CAPT = 2'b11
  } seq_state_t;

endpackage : ind_access_pkg

// ===== sram_test_bank.sv
// Seventeen test SRAMs written together and read together.
// Assumes the caller selects one of the read words.
`timescale 1ns/100ps

module sram_test_bank
  import ind_access_pkg::*;
(
  // Clock
  input  wire logic                          i_clk,
  // Broadcast write
  input  wire logic                          i_wr,
  input  wire logic [TST_ADDR_W-1:0]         i_addr,
  input  wire logic [REG_W-1:0]              i_wdata,
  // Registered read of every SRAM
  output logic      [SRAM_COUNT*REG_W-1:0]   o_rdata
);

  genvar g;

  // One array and one read register per SRAM
  generate
    for (g = 0; g < SRAM_COUNT; g++)
    begin : g_sram
      logic [REG_W-1:0] mem [SRAM_DEPTH];  // Storage words

      // Synchronous write and read
      always_ff @(posedge i_clk)
      begin
        if (i_wr)
        begin
          mem[i_addr] <= i_wdata;
        end
        o_rdata[g*REG_W +: REG_W] <= mem[i_addr];
      end
    end
  endgenerate

endmodule : sram_test_bank

// ===== ind_access_monitor.sv
// Checker for the indirect access port, watching its ports only.
// Assumes it is bound onto ind_access_port with one clock domain.
`timescale 1ns/100ps

module ind_access_monitor
  import ind_access_pkg::*;
(
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  // Register port
  input wire logic [7:0]            i_reg_addr,
  input wire logic                  i_reg_wr,
  input wire logic                  i_reg_rd,
  input wire logic [REG_W-1:0]      i_reg_wdata,
  input wire logic [REG_W-1:0]      o_reg_rdata,
  input wire logic                  o_reg_rvalid,
  input wire logic                  o_busy,
  input wire logic                  o_burst_mode,
  // Path select and indirect space
  input wire logic                  i_sram_test_path_select,
  input wire logic [IND_ADDR_W-1:0] o_ind_addr,
  input wire logic                  o_ind_wr,
  input wire logic                  o_ind_rd,
  input wire logic [REG_W-1:0]      o_ind_wdata,
  input wire logic [REG_W-1:0]      i_ind_rdata
);
  logic take; // Strobe accepted this edge
  logic dacc; // Offset is the data word or an alias
  assign take = (i_reg_wr | i_reg_rd) & ~o_busy;
  assign dacc = (i_reg_addr == OFS_IND_DATA) ||
                (i_reg_addr >= OFS_ALIAS_FIRST &&
                 i_reg_addr <= OFS_ALIAS_LAST);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_IND_RD_ONE: assert property (o_ind_rd |=> !o_ind_rd)
    else $error("indirect read strobe longer than one cycle");
  AST_STROBE_CAUSE: assert property ((o_ind_wr || o_ind_rd) |->
    ($past(take, 1) || $past(take, 2)))
    else $error("indirect strobe without an accepted access");
  AST_BUSY_BOUND: assert property (o_busy |-> ##[1:3] !o_busy)
    else $error("fetch held busy too long");
  AST_RVALID_CAUSE: assert property (o_reg_rvalid |->
    ($past(i_reg_rd, 1) || $past(i_reg_rd, 2) || $past(i_reg_rd, 3)))
    else $error("read answer without a read strobe");
  AST_WDATA: assert property (o_ind_wr |->
    o_ind_wdata == $past(i_reg_wdata))
    else $error("indirect write data differs from written word");
  AST_CTRL_ZERO: assert property (take && !i_reg_wr &&
    i_reg_addr == OFS_IND_CTRL |=> o_reg_rvalid && o_reg_rdata[12:11] == 2'b00)
    else $error("unused control bits not zero");
  AST_UNMAPPED: assert property (take && !i_reg_wr &&
    i_reg_addr == 8'h00 |=> o_reg_rvalid && o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_TEST_PATH: assert property (take && dacc && i_sram_test_path_select
    |=> !o_ind_rd && !o_ind_wr ##1 !o_ind_rd)
    else $error("indirect strobe on the test path");
  AST_BURST: assert property (take && i_reg_wr &&
    i_reg_addr == OFS_IND_CTRL |=> o_burst_mode == $past(i_reg_wdata[13]))
    else $error("burst flag does not follow control word");

  // Main scenarios
  CV_IND_RD: cover property (o_ind_rd ##2 o_reg_rvalid);
  CV_IND_WR: cover property (o_ind_wr);
  CV_TEST: cover property (take && dacc && i_sram_test_path_select);
endmodule : ind_access_monitor

bind ind_access_port ind_access_monitor u_mon (.i_clk, .i_reset,
  .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .o_busy, .o_burst_mode, .i_sram_test_path_select,
  .o_ind_addr, .o_ind_wr, .o_ind_rd, .o_ind_wdata, .i_ind_rdata);

// ===== ind_space_model.sv
// Model of the indirect register and memory space behind the port.
// Assumes one-cycle strobes; read data is valid the cycle after.
`timescale 1ns/100ps

module ind_space_model
  import ind_access_pkg::*;
(
  // Clock
  input  wire logic                  i_clk,
  // Strobes from the port
  input  wire logic [IND_ADDR_W-1:0] i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [REG_W-1:0]      i_wdata,
  // Read answer
  output logic      [REG_W-1:0]      o_rdata
);
  logic [REG_W-1:0] mem [0:2047]; // Indirect locations

  initial o_rdata = 16'h0000;

  // Store writes; answer reads next cycle, else scramble the bus
  always @(posedge i_clk)
  begin
    if (i_wr)
      mem[i_addr] <= i_wdata;
    if (i_rd)
      o_rdata <= mem[i_addr];
    else
      o_rdata <= ~o_rdata;
  end
endmodule : ind_space_model

// ===== indirect_access_ram_test_port_tb_top.sv
// Self-checking bench for the indirect access port and SRAM test path.
// Assumes the far side is ind_space_model and one 25 MHz clock.
`timescale 1ns/100ps

module indirect_access_ram_test_port_tb_top;
  import ind_access_pkg::*;

  logic        i_clk = 1'b0;              // Device clock
  logic        i_reset = 1'b1;            // Async reset
  logic [7:0]  i_reg_addr = 8'h00;        // Register offset
  logic        i_reg_wr = 1'b0;           // Write strobe
  logic        i_reg_rd = 1'b0;           // Read strobe
  logic [15:0] i_reg_wdata = 16'h0000;    // Write data
  logic        path = 1'b0;               // Test path select
  logic [15:0] o_reg_rdata, o_ind_wdata, ind_rdata;
  logic [10:0] o_ind_addr;
  logic        o_reg_rvalid, o_busy, o_burst_mode, o_ind_wr, o_ind_rd;
  logic [15:0] d1, d2;                    // Random data words, indirect and test SRAM
  logic [15:0] exq[$];                    // Expected indirect words
  integer      seed = 32'h1457;
  int          n_errors = 0, checked = 0, cyc = 0, s;

  always #20 i_clk = ~i_clk;

  ind_access_port uut (.i_clk, .i_reset, .i_reg_addr, .i_reg_wr,
    .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_busy,
    .o_burst_mode, .i_sram_test_path_select(path), .o_ind_addr,
    .o_ind_wr, .o_ind_rd, .o_ind_wdata, .i_ind_rdata(ind_rdata));
  ind_space_model u_model (.i_clk, .i_addr(o_ind_addr), .i_wr(o_ind_wr),
    .i_rd(o_ind_rd), .i_wdata(o_ind_wdata), .o_rdata(ind_rdata));

  // Compare one value
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  // Register read, wait for the answer, then compare
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string nm);
    int k;
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    for (k = 0; k < 8 && o_reg_rvalid !== 1'b1; k++)
      @(posedge i_clk);
    chk({nm, " rvalid"}, 16'h0001, {15'h0000, o_reg_rvalid});
    chk(nm, e, o_reg_rdata);
  endtask : rchk

  // Verdict and end of run
  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk(OFS_RAM_TEST_CTRL, 16'h0000, "test ctrl reset");
    rchk(OFS_IND_CTRL, 16'h0000, "ind ctrl reset");
    chk("data reset", 16'h0000, o_ind_wdata);
    chk("busy idle", 16'h0000, {15'h0000, o_busy});
    rchk(8'h00, 16'h0000, "unmapped");
    $display("test reset done");
    wr(OFS_IND_CTRL, 16'hF805);
    rchk(OFS_IND_CTRL, 16'hE005, "ind ctrl");
    chk("burst", 16'h0001, {15'h0000, o_burst_mode});
    d1 = $random(seed);
    d2 = $random(seed);
    exq.push_back(d1);
    exq.push_back(d2);
    wr(OFS_IND_DATA, d1);
    wr(OFS_ALIAS_FIRST, d2);
    wr(OFS_IND_CTRL, 16'h8005);
    rchk(OFS_IND_DATA, exq.pop_front(), "ind read 5");
    rchk(OFS_ALIAS_LAST, exq.pop_front(), "ind read 6");
    chk("burst off", 16'h0000, {15'h0000, o_burst_mode});
    d1 = $random(seed);
    wr(OFS_IND_CTRL, 16'h4007);
    wr(OFS_IND_DATA, d1);
    wr(OFS_IND_CTRL, 16'h8007);
    rchk(OFS_IND_DATA, d1, "ind read 7");
    wr(OFS_IND_CTRL, 16'h0007);
    wr(OFS_IND_DATA, 16'h0000);
    rchk(OFS_IND_CTRL, 16'h0007, "ind ctrl 7");
    chk("fetched data", d1, o_ind_wdata);
    $display("test indirect done");
    path <= 1'b1;
    d1 = $random(seed);
    d2 = $random(seed);
    wr(OFS_RAM_TEST_CTRL, 16'h831F);
    wr(OFS_IND_DATA, d1);
    rchk(OFS_RAM_TEST_CTRL, 16'h8000, "test addr wrap");
    wr(OFS_ALIAS_LAST, d2);
    for (s = 0; s < 17; s++)
    begin
      wr(OFS_RAM_TEST_CTRL, (s == 16) ? 16'h431F :
         (16'h031F | ((s < 8) ? 16'h2000 : 16'h0000) | 16'((s % 8) << 10)));
      rchk(OFS_IND_DATA, d1, "test sram read");
    end
    rchk(OFS_IND_DATA, d2, "test next addr");
    rchk(OFS_RAM_TEST_CTRL, 16'h4001, "test addr step");
    $display("test sram done");
    end_sim();
  end
endmodule : indirect_access_ram_test_port_tb_top
